// >>> hdl/stoc_top.sv
module stoc_top #(
  parameter int unsigned MS_CYCLES = stoc_pkg::CYC_PER_MS
) (
  // clock and reset
  input  wire logic                clock_i,
  input  wire logic                reset_n_i,
  // ahb-lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic [31:0]              hrdata,
  // safe inputs and fieldbus
  input  wire logic                safe_input_a_i,
  input  wire logic                safe_input_b_i,
  input  wire stoc_pkg::stoc_fb_s  safety_fieldbus_comm_i,
  // reset sources, run command, events
  input  wire stoc_pkg::stoc_rst_s reset_src_i,
  input  wire logic                on_cmd_i,
  input  wire logic                internal_fault_i,
  input  wire logic                external_fault_i,
  input  wire stoc_pkg::stoc_evt_s event_i,
  // drive outputs
  output logic                     torque_permit_o,
  output logic                     motor_run_o,
  output logic                     timed_safe_stop_o,
  output logic [15:0]              ramp_remaining_o,
  output logic                     torque_removed_warning_o,
  output logic                     channel_mismatch_warning_o,
  output logic                     irq_o
);
  typedef struct packed {
    logic [stoc_pkg::CTRL_W-1:0]  ctrl;
    logic [15:0]                  delay;
    logic [6:0]                   margin;
    logic [stoc_pkg::IRQ_W-1:0]   irq_st;
    logic [stoc_pkg::IRQ_W-1:0]   irq_msk;
    logic                         a_wr;
    logic [7:0]                   a_addr;
    logic [31:0]                  rdata;
    logic [15:0]                  mscnt;
    logic                         tick;
    logic                         int_lat;
    logic                         ext_lat;
    logic                         need_ack;
    logic                         di_inv;
    logic                         run;
    logic                         sto_d;
    logic                         exp_d;
    logic                         mis_d;
  } stoc_state_s;

  stoc_state_s s_r, s_nxt;
  logic        rst_meta_r, rst_n_r;

  logic [3:0]  func;
  logic        fb_en, auto_rs, ext_ss1, both_hi, mismatch;
  logic        di_sto, di_ss1, fb_sto, fb_ss1, ext_sto_req, ext_ss1_req;
  logic        sto_req, ss1_req, timing, expired, sto_active, man_rst;
  logic        t_start, t_quit, ack_evt, permit;
  logic [15:0] ramp_rem;
  localparam int IRQ_WL = stoc_pkg::IRQ_W;
  logic        a_ph, ack_due;
  logic [IRQ_WL-1:0] irq_set;

  function automatic logic [31:0] rd_mux(input logic [7:0] a, input stoc_state_s s,
                                         input logic [7:0] st, input logic [15:0] rr);
    unique case (a)
      stoc_pkg::A_CTRL:    rd_mux = {23'h0, s.ctrl};
      stoc_pkg::A_DELAY:   rd_mux = {16'h0, s.delay};
      stoc_pkg::A_MARGIN:  rd_mux = {25'h0, s.margin};
      stoc_pkg::A_STATUS:  rd_mux = {24'h0, st};
      stoc_pkg::A_IRQ_ST:  rd_mux = {27'h0, s.irq_st};
      stoc_pkg::A_IRQ_MSK: rd_mux = {27'h0, s.irq_msk};
      stoc_pkg::A_RAMP:    rd_mux = {16'h0, rr};
      default:             rd_mux = 32'h0000_0000;
    endcase
  endfunction

  // reset release through two flops
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // configuration decode
  assign func     = s_r.ctrl[stoc_pkg::CF_FUNC_LSB +: 4];
  assign fb_en    = s_r.ctrl[stoc_pkg::CF_FB_EN];
  assign auto_rs  = s_r.ctrl[stoc_pkg::CF_AUTO];
  assign ext_ss1  = s_r.ctrl[stoc_pkg::CF_EXT_SS1];
  assign both_hi  = safe_input_a_i && safe_input_b_i;
  assign mismatch = (func == stoc_pkg::FUNC_STO || func == stoc_pkg::FUNC_SS1)
                    && (safe_input_a_i != safe_input_b_i);

  // trigger sources, each evaluated on its own
  assign di_sto = (func == stoc_pkg::FUNC_STO) && !both_hi;
  assign di_ss1 = (func == stoc_pkg::FUNC_SS1) && !both_hi;
  assign fb_sto = fb_en && safety_fieldbus_comm_i.sto_cmd;
  assign fb_ss1 = fb_en && safety_fieldbus_comm_i.ss1_cmd;
  assign ext_sto_req = s_r.ext_lat && !ext_ss1;
  assign ext_ss1_req = s_r.ext_lat && ext_ss1;

  assign sto_req = di_sto || fb_sto || ext_sto_req || s_r.int_lat;
  assign ss1_req = di_ss1 || fb_ss1 || ext_ss1_req;
  assign sto_active = sto_req || expired;

  // timer start on a timed request with no immediate one, quit on an immediate request or when every timed request is gone (safe inputs: auto reset only)
  assign t_start = ss1_req && !sto_req;
  assign t_quit  = sto_req || (!fb_ss1 && !ext_ss1_req
                   && (func != stoc_pkg::FUNC_SS1 || (both_hi && auto_rs)));

  stoc_stop_timer u_timer (
    .clock_i    (clock_i),
    .rst_n_i    (rst_n_r),
    .tick_i     (s_r.tick),
    .start_i    (t_start),
    .quit_i     (t_quit),
    .delay_ms_i (s_r.delay),
    .margin_i   (s_r.margin),
    .timing_o   (timing),
    .expired_o  (expired),
    .ramp_rem_o (ramp_rem)
  );

  // manual reset from the selected source
  always_comb begin
    unique case (s_r.ctrl[stoc_pkg::CF_RSRC_LSB +: 2])
      stoc_pkg::RSRC_PANEL: man_rst = reset_src_i.panel;
      stoc_pkg::RSRC_DI:    man_rst = reset_src_i.di;
      stoc_pkg::RSRC_NSFB:  man_rst = reset_src_i.nsfb;
      default:              man_rst = 1'b0;
    endcase
  end

  // events needing reset only while the safety fieldbus is off
  assign ack_evt = !fb_en && (|event_i);
  assign ack_due = !sto_active && s_r.sto_d && s_r.di_inv && !auto_rs;
  assign permit  = !sto_active && !s_r.need_ack && !ack_due
                   && !s_r.ext_lat && !s_r.int_lat;

  assign a_ph = hsel && htrans[1] && hready;
  assign irq_set[stoc_pkg::IRQ_STO] = sto_active && !s_r.sto_d;
  assign irq_set[stoc_pkg::IRQ_EXP] = expired && !s_r.exp_d;
  assign irq_set[stoc_pkg::IRQ_MIS] = mismatch && !s_r.mis_d;
  assign irq_set[stoc_pkg::IRQ_INT] = internal_fault_i && !s_r.int_lat;
  assign irq_set[stoc_pkg::IRQ_ACK] = ack_evt;

  always_comb begin
    logic [7:0] stat;
    stat  = 8'h00;
    s_nxt = s_r;
    stat  = {s_r.int_lat, s_r.ext_lat, s_r.need_ack, expired, timing,
             sto_active, s_r.run, permit};

    // millisecond tick
    s_nxt.tick = 1'b0;
    if (s_r.mscnt == 16'(MS_CYCLES - 1)) begin
      s_nxt.mscnt = 16'h0000;
      s_nxt.tick  = 1'b1;
    end else begin
      s_nxt.mscnt = s_r.mscnt + 16'h0001;
    end

    // bus: read data registered in the address phase, writes in the data phase
    s_nxt.a_wr = a_ph && hwrite;
    if (a_ph) begin
      s_nxt.a_addr = haddr[7:0];
      s_nxt.rdata  = rd_mux(haddr[7:0], s_r, stat, ramp_rem);
    end
    if (s_r.a_wr) begin
      unique case (s_r.a_addr)
        stoc_pkg::A_CTRL:    s_nxt.ctrl    = hwdata[stoc_pkg::CTRL_W-1:0];
        stoc_pkg::A_DELAY:   s_nxt.delay   = hwdata[15:0];
        stoc_pkg::A_MARGIN:  s_nxt.margin  = (hwdata[6:0] > stoc_pkg::MARGIN_MAX) ?
                                             stoc_pkg::MARGIN_MAX : hwdata[6:0];
        stoc_pkg::A_IRQ_MSK: s_nxt.irq_msk = hwdata[IRQ_WL-1:0];
        default: ;
      endcase
    end
    // sticky events, set wins over write-one-clear
    if (s_r.a_wr && s_r.a_addr == stoc_pkg::A_IRQ_ST) begin
      s_nxt.irq_st = s_r.irq_st & ~hwdata[IRQ_WL-1:0];
    end
    s_nxt.irq_st = s_nxt.irq_st | irq_set;

    // fault latches
    if (internal_fault_i) begin
      s_nxt.int_lat = 1'b1;
    end
    if (external_fault_i) begin
      s_nxt.ext_lat = 1'b1;
    end else if (man_rst) begin
      s_nxt.ext_lat = 1'b0;
    end

    // acknowledge demand: safe input manual mode, or config events
    s_nxt.sto_d = sto_active;
    s_nxt.exp_d = expired;
    s_nxt.mis_d = mismatch;
    if (di_sto || di_ss1) begin
      s_nxt.di_inv = 1'b1;
    end
    if (s_r.need_ack && man_rst && !sto_active) begin
      s_nxt.need_ack = 1'b0;
    end
    if (!sto_active && s_r.sto_d) begin
      s_nxt.di_inv = 1'b0;
      if (s_r.di_inv && !auto_rs) begin
        s_nxt.need_ack = 1'b1;
      end
    end
    if (ack_evt) begin
      s_nxt.need_ack = 1'b1;
    end

    // run only on an on command while torque is permitted
    if (!permit) begin
      s_nxt.run = 1'b0;
    end else if (on_cmd_i) begin
      s_nxt.run = 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      s_r <= '{ctrl: stoc_pkg::CTRL_RST, delay: stoc_pkg::DELAY_RST,
               margin: stoc_pkg::MARGIN_RST, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = s_r.rdata;

  assign torque_permit_o            = permit;
  assign motor_run_o                = s_r.run;
  assign timed_safe_stop_o          = timing;
  assign ramp_remaining_o           = ramp_rem;
  assign torque_removed_warning_o   = (sto_active && !mismatch) || expired
                                      || fb_sto;
  assign channel_mismatch_warning_o = mismatch;
  assign irq_o                      = |(s_r.irq_st & s_r.irq_msk);

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_r);

  a_di_sto_cut: assert property (
    (func == stoc_pkg::FUNC_STO) && !both_hi |-> !torque_permit_o)
    else $error("torque permitted with safe input low");
  a_warn_kind: assert property (
    (func == stoc_pkg::FUNC_STO) && !safe_input_a_i && !safe_input_b_i
    |-> torque_removed_warning_o && !channel_mismatch_warning_o)
    else $error("wrong warning for both channels low");
  a_mis_flag: assert property (
    (func == stoc_pkg::FUNC_STO) && (safe_input_a_i != safe_input_b_i)
    |-> channel_mismatch_warning_o && !torque_permit_o)
    else $error("channel mismatch not flagged");
  a_fb_gate: assert property (
    !fb_en && !s_r.ext_lat && !s_r.int_lat && (func != stoc_pkg::FUNC_STO)
    && (func != stoc_pkg::FUNC_SS1) && !expired |-> !sto_active)
    else $error("fieldbus command acted while disabled");
  a_fb_sto_cut: assert property (
    fb_en && safety_fieldbus_comm_i.sto_cmd |-> !torque_permit_o && torque_removed_warning_o)
    else $error("active fieldbus stop left torque on");
  a_exit_needs_all: assert property (
    torque_permit_o |-> !fb_sto && !di_sto)
    else $error("torque permitted with a request active");
  a_auto_run: assert property (
    torque_permit_o && on_cmd_i |=> motor_run_o)
    else $error("on command ignored while permitted");
  a_run_needs_on: assert property (
    !motor_run_o && !on_cmd_i |=> !motor_run_o)
    else $error("motor started without on command");
  a_manual_ack: assert property (
    $fell(sto_active) && s_r.di_inv && !auto_rs |=> !torque_permit_o [*2])
    else $error("manual mode restarted without reset");
  a_pending_ack: assert property (
    !sto_active && s_r.sto_d && s_r.di_inv && !auto_rs
    |-> !torque_permit_o ##1 s_r.need_ack)
    else $error("permit leaked while acknowledge pending");
  a_ack_clears: assert property (
    s_r.need_ack && man_rst && !sto_active && !ack_evt && !ack_due |=> !s_r.need_ack)
    else $error("acknowledge not taken");
  a_ext_latched: assert property (
    $rose(s_r.ext_lat) && !man_rst ##1 !man_rst |=> !torque_permit_o)
    else $error("external fault cleared without reset");
  a_ack_holds: assert property (
    s_r.need_ack && !man_rst |=> s_r.need_ack)
    else $error("acknowledge cleared without reset");
  a_fb_self_reset: assert property (
    fb_en && !safety_fieldbus_comm_i.sto_cmd && !di_sto && !s_r.ext_lat && !s_r.int_lat
    && !expired && !s_r.need_ack && !ack_due |-> torque_permit_o)
    else $error("inactive fieldbus command did not restore torque");
  a_bus_quit: assert property (
    timing && fb_en && !fb_ss1 && !s_r.ext_lat && (func != stoc_pkg::FUNC_SS1) |=> !timing)
    else $error("inactive fieldbus timed stop kept timing");
  a_int_sticky: assert property (
    s_r.int_lat |=> s_r.int_lat && !torque_permit_o)
    else $error("internal failure released");
  a_ack_event: assert property (
    ack_evt |=> s_r.need_ack && !torque_permit_o)
    else $error("config event did not demand reset");
  a_bus_evt_free: assert property (
    fb_en && !s_r.need_ack && !ack_due |=> !s_r.need_ack)
    else $error("reset demanded with fieldbus enabled");
  a_sto_preempt: assert property (
    sto_req && timing |=> !timing)
    else $error("timed stop not interrupted");
  a_ss1_start: assert property (
    t_start && !timing && !expired && !t_quit && (s_r.delay != 16'h0000) |=> timing)
    else $error("timed stop did not start");
  a_expire_cut: assert property (
    $rose(expired) |-> !torque_permit_o && torque_removed_warning_o ##1 !motor_run_o)
    else $error("torque kept after expiry");
  a_run_drop: assert property (
    !torque_permit_o |=> !motor_run_o)
    else $error("motor kept running without permit");

  c_di_sto:    cover property ($rose(di_sto) ##[1:20] $fell(di_sto));
  c_ss1_exp:   cover property ($rose(timing) ##[1:1000] $rose(expired));
  c_ss1_break: cover property (timing ##1 sto_req);
  c_restart:   cover property ($fell(s_r.need_ack) ##[1:20] motor_run_o);
  c_ext_ss1:   cover property ($rose(s_r.ext_lat) ##[1:4] timing);
endmodule // stoc_top

// >>> hdl/stoc_pkg.sv
package stoc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned CYC_PER_MS    = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_DELAY   = 8'h04;
  localparam logic [7:0] A_MARGIN  = 8'h08;
  localparam logic [7:0] A_STATUS  = 8'h0c;
  localparam logic [7:0] A_IRQ_ST  = 8'h10;
  localparam logic [7:0] A_IRQ_MSK = 8'h14;
  localparam logic [7:0] A_RAMP    = 8'h18;

  localparam int CF_FUNC_LSB = 0;
  localparam int CF_FB_EN    = 4;
  localparam int CF_AUTO     = 5;
  localparam int CF_EXT_SS1  = 6;
  localparam int CF_RSRC_LSB = 7;
  localparam int CTRL_W      = 9;

  localparam logic [3:0] FUNC_STO   = 4'h0;
  localparam logic [3:0] FUNC_SS1   = 4'h9;
  localparam logic [1:0] RSRC_PANEL = 2'h0;
  localparam logic [1:0] RSRC_DI    = 2'h1;
  localparam logic [1:0] RSRC_NSFB  = 2'h2;

  localparam logic [8:0]  CTRL_RST   = 9'h00f;
  localparam logic [15:0] DELAY_RST  = 16'h03e8;
  localparam logic [6:0]  MARGIN_RST = 7'h0a;
  localparam logic [6:0]  MARGIN_MAX = 7'h64;

  localparam int IRQ_STO = 0;
  localparam int IRQ_EXP = 1;
  localparam int IRQ_MIS = 2;
  localparam int IRQ_INT = 3;
  localparam int IRQ_ACK = 4;
  localparam int IRQ_W   = 5;

  typedef struct packed {
    logic sto_cmd;
    logic ss1_cmd;
  } stoc_fb_s;

  typedef struct packed {
    logic panel;
    logic di;
    logic nsfb;
  } stoc_rst_s;

  typedef struct packed {
    logic cust_aborted;
    logic cust_done;
    logic gen_reset;
    logic fb_init;
  } stoc_evt_s;

  typedef enum logic [1:0] {T_IDLE, T_RUN, T_DONE} stoc_tmr_e;
endpackage

// >>> hdl/stoc_stop_timer.sv
module stoc_stop_timer (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // control
  input  wire logic        tick_i,
  input  wire logic        start_i,
  input  wire logic        quit_i,
  input  wire logic [15:0] delay_ms_i,
  input  wire logic [6:0]  margin_i,
  // status
  output logic             timing_o,
  output logic             expired_o,
  output logic [15:0]      ramp_rem_o
);
  typedef struct packed {
    stoc_pkg::stoc_tmr_e st;
    logic [15:0]         cnt;
    logic [15:0]         ramp;
  } stoc_tmr_s;

  stoc_tmr_s s_r, s_nxt;
  logic [22:0] prod;
  logic [15:0] marg_ms;

  assign prod    = delay_ms_i * margin_i;
  assign marg_ms = 16'(prod / 23'd100);

  always_comb begin
    s_nxt = s_r;
    unique case (s_r.st)
      stoc_pkg::T_IDLE: begin
        if (start_i && !quit_i) begin
          s_nxt.cnt  = delay_ms_i;
          s_nxt.ramp = delay_ms_i - marg_ms;
          s_nxt.st   = (delay_ms_i == 16'h0000) ? stoc_pkg::T_DONE : stoc_pkg::T_RUN;
        end
      end
      stoc_pkg::T_RUN: begin
        if (quit_i) begin
          s_nxt.st   = stoc_pkg::T_IDLE;
          s_nxt.ramp = 16'h0000;
        end else if (tick_i) begin
          s_nxt.cnt = s_r.cnt - 16'h0001;
          if (s_r.ramp != 16'h0000) begin
            s_nxt.ramp = s_r.ramp - 16'h0001;
          end
          if (s_r.cnt == 16'h0001) begin
            s_nxt.st = stoc_pkg::T_DONE;
          end
        end
      end
      stoc_pkg::T_DONE: begin
        s_nxt.ramp = 16'h0000;
        if (quit_i) begin
          s_nxt.st = stoc_pkg::T_IDLE;
        end
      end
      default: s_nxt.st = stoc_pkg::T_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '{st: stoc_pkg::T_IDLE, cnt: 16'h0000, ramp: 16'h0000};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign timing_o   = (s_r.st == stoc_pkg::T_RUN);
  assign expired_o  = (s_r.st == stoc_pkg::T_DONE);
  assign ramp_rem_o = s_r.ramp;

  a_start_runs: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (s_r.st == stoc_pkg::T_IDLE) && start_i && !quit_i && (delay_ms_i != 16'h0000)
    |=> timing_o && (s_r.cnt == $past(delay_ms_i)))
    else $error("timer did not load delay on start");
  a_expiry_edge: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    timing_o && tick_i && !quit_i && (s_r.cnt == 16'h0001) |=> expired_o)
    else $error("timer did not expire on last tick");
endmodule // stoc_stop_timer

// >>> bench/stoc_host_model.sv
module stoc_host_model #(
  parameter int unsigned PERIOD = 4
) (
  // clock and reset
  input  wire logic         clock_i,
  input  wire logic         reset_n_i,
  // requests from the bench
  input  wire logic         sto_req_i,
  input  wire logic         ss1_req_i,
  // command frame towards the drive
  output stoc_pkg::stoc_fb_s fb_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned cnt_r;
  // command resent every frame, active or inactive, not only on change
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_r <= 0;
      fb_o  <= '0;
    end else if (cnt_r == PERIOD - 1) begin
      cnt_r <= 0;
      fb_o  <= '{sto_cmd: sto_req_i, ss1_cmd: ss1_req_i};
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end
endmodule // stoc_host_model

// >>> bench/test_stoc_top.sv
module test_stoc_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_i, reset_n_i, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic        sa, sb, sto_req, ss1_req, on_cmd, int_f, ext_f;
  logic [2:0]  rs;
  logic [3:0]  evt;
  logic        permit, run, tss, w68, channel_mismatch_warning, irq;
  logic [15:0] ramp;
  stoc_pkg::stoc_fb_s fb;
  int          err_total, compares;

  stoc_top #(.MS_CYCLES(10)) stoc_top_i (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .safe_input_a_i(sa), .safe_input_b_i(sb),
    .safety_fieldbus_comm_i(fb), .reset_src_i(rs), .on_cmd_i(on_cmd),
    .internal_fault_i(int_f), .external_fault_i(ext_f), .event_i(evt),
    .torque_permit_o(permit), .motor_run_o(run), .timed_safe_stop_o(tss),
    .ramp_remaining_o(ramp), .torque_removed_warning_o(w68),
    .channel_mismatch_warning_o(channel_mismatch_warning), .irq_o(irq));
  stoc_host_model stoc_host_model_i (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .sto_req_i(sto_req), .ss1_req_i(ss1_req), .fb_o(fb));

  initial begin
    clock_i = 0;
    forever #10 clock_i = ~clock_i;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clock_i);
    hsel <= 1; haddr <= {24'h0, a}; htrans <= 2'b10; hwrite <= w;
    @(posedge clock_i);
    while (hreadyout !== 1'b1) @(posedge clock_i);
    hsel <= 0; htrans <= 2'b00; hwdata <= d;
    @(posedge clock_i);
    while (hreadyout !== 1'b1) @(posedge clock_i);
    rd = hrdata;
  endtask
  task automatic cfg(input logic [3:0] f, input logic fbe, input logic au, input logic [1:0] r);
    ahb(stoc_pkg::A_CTRL, 1, {23'h0, r, 1'b0, au, fbe, f});
  endtask
  task automatic pulse_rs(input logic [2:0] v);
    @(posedge clock_i) rs <= v;
    @(posedge clock_i) rs <= 0;
    cyc(2);
  endtask
  task automatic pulse_on();
    @(posedge clock_i) on_cmd <= 1;
    @(posedge clock_i) on_cmd <= 0;
    cyc(2);
  endtask
  task automatic chans(input logic a, input logic b, input int n);
    @(posedge clock_i) begin
      sa <= a;
      sb <= b;
    end
    cyc(n);
  endtask
  task automatic do_reset();
    @(posedge clock_i) reset_n_i <= 0;
    repeat (3) @(posedge clock_i);
    reset_n_i <= 1;
    cyc(3);
  endtask

  task automatic t_regs();
    logic [7:0]  a [5] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h1c};
    logic [31:0] e [5] = '{{23'h0, stoc_pkg::CTRL_RST}, {16'h0, stoc_pkg::DELAY_RST},
                           {25'h0, stoc_pkg::MARGIN_RST}, 32'h0, 32'h0};
    for (int i = 0; i < 5; i++) begin
      ahb(a[i], 0, 0);
      chk(rd, e[i], "register reset value");
    end
    chk(hresp, 0, "bus response okay");
    chk(permit, 1, "permit with defaults");
    $display("test regs done");
  endtask

  task automatic t_sto_di();
    cfg(stoc_pkg::FUNC_STO, 0, 1, stoc_pkg::RSRC_PANEL);
    for (int i = 0; i < 4; i++) begin
      chans(i[1], i[0], 2);
      chk(permit, i == 3, "permit per channels");
      chk(w68, i == 0, "removed warning");
      chk(channel_mismatch_warning, i == 1 || i == 2, "mismatch warning");
    end
    $display("test sto_di done");
  endtask

  task automatic t_fieldbus();
    cfg(4'hf, 0, 1, 0);
    sto_req <= 1;
    cyc(10);
    chk(permit, 1, "bus command ignored when disabled");
    cfg(4'hf, 1, 1, 0);
    cyc(10);
    chk(permit, 0, "bus torque-off");
    chk(w68, 1, "bus torque-off warning");
    sto_req <= 0;
    cyc(10);
    chk(permit, 1, "bus inactive resets itself");
    chk(w68, 0, "warning cleared");
    ss1_req <= 1;
    cyc(10);
    chk(tss, 1, "bus timed stop starts");
    ss1_req <= 0;
    cyc(10);
    chk(tss, 0, "bus timed stop quits");
    $display("test fieldbus done");
  endtask

  task automatic t_restart();
    for (int r = 0; r < 3; r++) begin
      cfg(stoc_pkg::FUNC_STO, 0, 0, r[1:0]);
      chans(0, 0, 3);
      chk(run, 0, "run off in torque-off");
      chans(1, 1, 3);
      chk(permit, 0, "manual needs acknowledge");
      pulse_on();
      chk(run, 0, "on ignored before acknowledge");
      pulse_rs(3'b100 >> ((r + 1) % 3));
      chk(permit, 0, "unselected source ignored");
      pulse_rs(3'b100 >> r);
      chk(permit, 1, "selected source acknowledges");
      pulse_on();
      chk(run, 1, "run after acknowledge");
    end
    cfg(stoc_pkg::FUNC_STO, 0, 1, 0);
    chans(0, 0, 3);
    chans(1, 1, 3);
    chk(permit, 1, "automatic exit");
    pulse_on();
    chk(run, 1, "automatic run on command");
    $display("test restart done");
  endtask

  task automatic t_timed();
    int n;
    cfg(stoc_pkg::FUNC_SS1, 0, 1, 0);
    ahb(stoc_pkg::A_DELAY, 1, 32'd20);
    ahb(stoc_pkg::A_MARGIN, 1, 32'd10);
    ahb(stoc_pkg::A_IRQ_MSK, 1, 32'h2);
    chans(0, 1, 1);
    chk(tss, 1, "timer starts on one low channel");
    chk(ramp, 32'd18, "ramp is delay less margin");
    n = 1;
    while (permit === 1'b1 && n < 400) begin
      cyc(1);
      n++;
    end
    chk(n >= 185 && n <= 215, 1, "expiry after delay");
    chk(ramp, 0, "ramp ended before expiry");
    chk(w68, 1, "expiry removes torque");
    cyc(1);
    chk(irq, 1, "expiry interrupt");
    ahb(stoc_pkg::A_IRQ_ST, 0, 0);
    chk(rd[1], 1, "expiry status bit");
    ahb(stoc_pkg::A_IRQ_ST, 1, 32'h2);
    cyc(2);
    chk(irq, 0, "interrupt cleared");
    ahb(stoc_pkg::A_IRQ_MSK, 1, 0);
    chans(1, 1, 3);
    chk(permit, 1, "exit after channels high");
    chk(tss, 0, "timer idle");
    $display("test timed done");
  endtask

  task automatic t_priority();
    cfg(stoc_pkg::FUNC_SS1, 1, 1, 0);
    chans(0, 0, 3);
    chk(tss, 1, "timed stop running");
    sto_req <= 1;
    cyc(8);
    chk(permit, 0, "immediate overrides timed stop");
    sto_req <= 0;
    chans(1, 1, 8);
    chk(permit, 1, "all sources inactive");
    cfg(stoc_pkg::FUNC_STO, 1, 1, 0);
    chans(0, 0, 8);
    chk(permit, 0, "channels low, bus inactive");
    sto_req <= 1;
    chans(1, 1, 8);
    chk(permit, 0, "channels high, bus active");
    sto_req <= 0;
    cyc(8);
    chk(permit, 1, "both inactive");
    $display("test priority done");
  endtask

  task automatic t_faults();
    cfg(stoc_pkg::FUNC_STO, 0, 1, stoc_pkg::RSRC_PANEL);
    @(posedge clock_i) ext_f <= 1;
    @(posedge clock_i) ext_f <= 0;
    cyc(2);
    chk(permit, 0, "external fault latched in auto mode");
    pulse_rs(3'b100);
    chk(permit, 1, "external fault reset");
    @(posedge clock_i) int_f <= 1;
    @(posedge clock_i) int_f <= 0;
    pulse_rs(3'b100);
    chk(permit, 0, "internal fault survives manual reset");
    do_reset();
    chk(permit, 1, "internal fault cleared by power cycle");
    @(posedge clock_i) evt <= 4'b0100;
    @(posedge clock_i) evt <= 0;
    cyc(2);
    chk(permit, 0, "event needs reset, bus off");
    pulse_rs(3'b100);
    chk(permit, 1, "event reset");
    cfg(4'hf, 1, 1, 0);
    @(posedge clock_i) evt <= 4'b1000;
    @(posedge clock_i) evt <= 0;
    cyc(2);
    chk(permit, 1, "event free with bus on");
    ahb(stoc_pkg::A_CTRL, 1, 32'h0000_006f);
    @(posedge clock_i) ext_f <= 1;
    @(posedge clock_i) ext_f <= 0;
    cyc(2);
    chk(tss, 1, "external fault starts timed stop");
    chk(permit, 0, "external fault holds torque off");
    pulse_rs(3'b100);
    chk(tss, 0, "reset quits external timed stop");
    $display("test faults done");
  endtask

  task automatic close_out();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    reset_n_i = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hwdata = 0;
    sa = 1; sb = 1; sto_req = 0; ss1_req = 0; on_cmd = 0; int_f = 0; ext_f = 0;
    rs = 0; evt = 0; err_total = 0; compares = 0;
    repeat (3) @(posedge clock_i);
    reset_n_i <= 1;
    cyc(3);
    t_regs();
    t_sto_di();
    t_fieldbus();
    t_restart();
    t_timed();
    t_priority();
    t_faults();
    close_out();
  end

  initial begin
    repeat (8000) @(posedge clock_i);
    err_total++;
    $display("CHECK FAILED t=%0t timeout", $time);
    close_out();
  end
endmodule // test_stoc_top
